// ==== rtl/pgc_cfg.svh ====
// pgc_cfg.svh: offsets, field positions, reset values for the page 2 register bank
// assumes: included by the bank module and the bench, apb byte addressing
`ifndef PGC_CFG_SVH
`define PGC_CFG_SVH

// register indices (byte address is four times the index)
`define PGC_IDX_EEE_CTRL 5'h11
`define PGC_IDX_PART_ID 5'h12
`define PGC_IDX_MAC_IF 5'h14
`define PGC_IDX_PAGE_SEL 5'h1f
`define PGC_IDX_SOFT_RST 5'h00
`define PGC_PAGE_MAIN 16'h0000
`define PGC_PAGE_EXT2 16'h0002
`define PGC_SOFT_RST_BIT 15

// energy efficient control fields
`define PGC_EEE_TE_BIT 15
`define PGC_EEE_RSV14_BIT 14
`define PGC_EEE_LED_HI 13
`define PGC_EEE_LED_LO 10
`define PGC_EEE_LINK_BIT 8
`define PGC_EEE_GIG_BIT 7
`define PGC_EEE_FAST_BIT 6
`define PGC_EEE_FORCE_BIT 5
`define PGC_EEE_LPI_BIT 4
`define PGC_EEE_INH_FTX_BIT 3
`define PGC_EEE_INH_FRX_BIT 2
`define PGC_EEE_INH_GTX_BIT 1
`define PGC_EEE_INH_GRX_BIT 0
`define PGC_EEE_RW_MASK 16'hfc3f
`define PGC_EEE_RST 16'h0000

// part identification fields
`define PGC_ID_TEMP_BIT 15
`define PGC_ID_DASH_HI 7

// mac interface control fields
`define PGC_MAC_CLKOFF_BIT 11
`define PGC_MAC_REV_BIT 7
`define PGC_MAC_DLY_HI 6
`define PGC_MAC_DLY_LO 4
`define PGC_MAC_RW_MASK 16'h08f0
`define PGC_MAC_RST 16'h0800

// speed select code of control register 0 bits 6 and 13
`define PGC_SPEED_GIG 2'b10

`endif

// ==== rtl/pgc_pkg.sv ====
// pgc_pkg.sv: types for the page 2 register bank
// assumes: encodings are literal here, nothing is taken from pgc_cfg.svh
package pgc_pkg;
    typedef enum logic [1:0] {
        PGC_SPD_10 = 2'b00,
        PGC_SPD_100 = 2'b01,
        PGC_SPD_1000 = 2'b10,
        PGC_SPD_NONE = 2'b11
    } pgc_speed_t;

    typedef enum logic [1:0] {
        PGC_ST_IDLE = 2'b00,
        PGC_ST_ACCESS = 2'b01
    } pgc_bus_st_t;

    typedef struct packed {
        logic [7:0] data;
        logic lpi;
    } pgc_rx_t;

    typedef struct packed {
        logic lpi;
        logic idle;
    } pgc_tx_t;

    typedef struct packed {
        pgc_bus_st_t st;
        logic [15:0] page;
        logic [15:0] eee;
        logic [15:0] mac;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [3:0] led;
        logic rx_clk;
        pgc_rx_t rx;
        logic line_lpi;
        logic gen_lpi;
        logic te_en;
        logic gig_force;
        logic [2:0] rx_dly;
    } pgc_state_t;
endpackage

// ==== rtl/pgc_bank.sv ====
// pgc_bank.sv: page 2 eee and mac interface configuration bank with its datapath hooks
// assumes: apb slave on core_clk_in, link inputs synchronous to the same clock
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "pgc_cfg.svh"

// Behaviour
// - bit 15 enables 10BASE-Te mode
// - bits 13:10 invert each LED polarity
// - bit 8 link up, bit 7 gigabit EEE
// - bit 6 reports 100BASE-TX EEE enabled
// - bit 5 forces gigabit link without master/slave while the gigabit speed select is set
// - bit 4 transmits LPI, ignores MAC data
// - bit 3 blocks 100BASE-TX transmit LPI
// - bit 2 blocks 100BASE-TX receive LPI
// - bit 1 blocks gigabit transmit LPI
// - bit 0 blocks gigabit receive LPI
// - bit 15 reads temperature grade
// - bits 7:0 read BCD dash number
// - bit 11 holds receive clock low
// - bit 7 reverses receive data order
// - bits 6:4 select receive clock delay
module pgc_bank #(
    parameter logic [7:0] DASH_BCD = 8'h01, // arbitrary value
    parameter logic INDUSTRIAL = 1'b0
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // phy status
    input wire logic link_up_in,
    input wire logic eee_gig_in,
    input wire logic eee_fast_in,
    input wire pgc_pkg::pgc_speed_t speed_in,
    input wire logic [1:0] speed_sel_in,
    input wire logic gmii_mode_in,
    // led path
    input wire logic [3:0] led_act_in,
    output logic [3:0] indicator_outputs_out,
    // transmit lpi path
    input wire logic mac_tx_lpi_in,
    output logic line_tx_lpi_out,
    output logic packet_generator_lpi_out,
    // receive path
    input wire logic line_rx_lpi_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_clk_raw_in,
    output pgc_pkg::pgc_rx_t mac_rx_out,
    output logic receive_clock_output_out,
    output logic [2:0] rx_clk_delay_out,
    // mode controls
    output logic te_mode_out,
    output logic gig_force_out
);
    import pgc_pkg::*;

    pgc_state_t s_q;
    pgc_state_t s_d;
    logic [4:0] idx;
    logic ext_page;
    logic hit;
    logic [15:0] rd;
    logic [15:0] wv;
    logic [15:0] eee_rd;
    logic [7:0] rev;
    logic [7:0] rev_full;
    logic [3:0] rev_nib;
    logic [3:0] led_drv;
    logic aligned;
    logic sel_page;
    logic sel_rst;
    logic sel_eee;
    logic sel_mac;
    logic acc_fire;
    logic wr_fire;
    logic [15:0] id_rd;
    logic tx_inh;
    logic rx_inh;

    assign idx = paddr_in[6:2];
    assign wv = pwdata_in[15:0];
    assign aligned = (paddr_in[1:0] == 2'b00);

    // gmii mirrors all eight receive bits, rgmii only the low nibble
    pgc_lane_rev #(
        .WIDTH(8)
    ) u_rev_full (
        .lane_in(rx_data_in),
        .lane_out(rev_full)
    );
    pgc_lane_rev #(
        .WIDTH(4)
    ) u_rev_nib (
        .lane_in(rx_data_in[3:0]),
        .lane_out(rev_nib)
    );

    // one polarity stage per indicator pin
    for (genvar g = 0; g < 4; g++)
    begin
        pgc_led_pol u_led_pol (
            .act_in(led_act_in[g]),
            .invert_in(s_q.eee[`PGC_EEE_LED_LO + g]),
            .pin_out(led_drv[g])
        );
    end

    // register selects; indices 16..30 answer only on page two
    always_comb
    begin
        sel_page = (idx == `PGC_IDX_PAGE_SEL);
        sel_rst = (idx == `PGC_IDX_SOFT_RST);
        sel_eee = ext_page && (idx == `PGC_IDX_EEE_CTRL);
        sel_mac = ext_page && (idx == `PGC_IDX_MAC_IF);

        // a transfer fires at its access edge; writes need a mapped aligned word
        acc_fire = (s_q.st == PGC_ST_ACCESS) && psel_in && penable_in;
        wr_fire = acc_fire && pwrite_in && hit && aligned;
    end

    // part identification word; the reserved bits read zero
    always_comb
    begin
        id_rd = 16'h0000;
        id_rd[`PGC_ID_TEMP_BIT] = INDUSTRIAL;
        id_rd[`PGC_ID_DASH_HI:0] = DASH_BCD;
    end

    // lpi inhibits apply only in the speed that they name
    always_comb
    begin
        tx_inh = 1'b0;
        rx_inh = 1'b0;
        case (speed_in)
            PGC_SPD_100:
            begin
                tx_inh = s_q.eee[`PGC_EEE_INH_FTX_BIT];
                rx_inh = s_q.eee[`PGC_EEE_INH_FRX_BIT];
            end
            PGC_SPD_1000:
            begin
                tx_inh = s_q.eee[`PGC_EEE_INH_GTX_BIT];
                rx_inh = s_q.eee[`PGC_EEE_INH_GRX_BIT];
            end
            default:
            begin
                tx_inh = 1'b0;
                rx_inh = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        // page gate on registers 16..30
        ext_page = (s_q.page == `PGC_PAGE_EXT2);
        hit = 1'b1;
        rd = 16'h0000;
        eee_rd = s_q.eee;
        eee_rd[`PGC_EEE_LINK_BIT] = link_up_in;
        eee_rd[`PGC_EEE_GIG_BIT] = eee_gig_in;
        eee_rd[`PGC_EEE_FAST_BIT] = eee_fast_in;
        if (idx == `PGC_IDX_PAGE_SEL)
        begin
            rd = s_q.page;
        end
        else if (idx == `PGC_IDX_SOFT_RST)
        begin
            rd = 16'h0000;
        end
        else if (ext_page && idx == `PGC_IDX_EEE_CTRL)
        begin
            rd = eee_rd;
        end
        else if (ext_page && idx == `PGC_IDX_PART_ID)
        begin
            rd = id_rd;
        end
        else if (ext_page && idx == `PGC_IDX_MAC_IF)
        begin
            rd = s_q.mac;
        end
        else
        begin
            hit = 1'b0;
        end
    end

    always_comb
    begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        case (s_q.st)
            PGC_ST_IDLE:
            begin
                if (psel_in && !penable_in)
                begin
                    s_d.st = PGC_ST_ACCESS;
                end
            end
            PGC_ST_ACCESS:
            begin
                // one wait state: the access edge latches, the answer follows
                if (acc_fire)
                begin
                    s_d.pready = 1'b1;
                    s_d.pslverr = !hit || !aligned;
                    s_d.prdata = {16'h0000, rd};
                    s_d.st = PGC_ST_IDLE;
                end
                else if (!psel_in)
                begin
                    // master withdrew before the access phase
                    s_d.st = PGC_ST_IDLE;
                end
                if (wr_fire && sel_page)
                begin
                    s_d.page = wv;
                end
                if (wr_fire && sel_rst)
                begin
                    // software reset leaves sticky bits untouched
                    s_d.page = `PGC_PAGE_MAIN;
                end
                if (wr_fire && sel_eee)
                begin
                    s_d.eee = wv & `PGC_EEE_RW_MASK;
                end
                if (wr_fire && sel_mac)
                begin
                    s_d.mac = wv & `PGC_MAC_RW_MASK;
                end
            end
            default:
            begin
                s_d.st = PGC_ST_IDLE;
            end
        endcase
        if (s_q.pready)
        begin
            s_d.st = PGC_ST_IDLE;
        end

        // mode controls
        s_d.te_en = s_q.eee[`PGC_EEE_TE_BIT];
        // led pins drive active low until their polarity bit is set
        s_d.led = led_drv;
        // forced gigabit link needs the gigabit speed select
        s_d.gig_force = s_q.eee[`PGC_EEE_FORCE_BIT]
            && (speed_sel_in == `PGC_SPEED_GIG);
        // generator lpi overrides the mac; its enable holds until software clears this bit
        s_d.gen_lpi = s_q.eee[`PGC_EEE_LPI_BIT];
        s_d.line_lpi = s_q.eee[`PGC_EEE_LPI_BIT]
            || (mac_tx_lpi_in && !tx_inh);
        // receive lpi is held back from the mac when inhibited
        s_d.rx.lpi = line_rx_lpi_in && !rx_inh;

        // receive lane order
        rev = gmii_mode_in ? rev_full : {rx_data_in[7:4], rev_nib};
        s_d.rx.data = s_q.mac[`PGC_MAC_REV_BIT] ? rev : rx_data_in;
        s_d.rx_clk = s_q.mac[`PGC_MAC_CLKOFF_BIT] ? 1'b0 : rx_clk_raw_in;
        s_d.rx_dly = s_q.mac[`PGC_MAC_DLY_HI:`PGC_MAC_DLY_LO];
    end

    // hardware reset is the only way back to the sticky defaults
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_q <= '0;
            s_q.eee <= `PGC_EEE_RST;
            s_q.mac <= `PGC_MAC_RST;
            s_q.page <= `PGC_PAGE_MAIN;
            s_q.led <= 4'hf;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // every output comes straight from the state register
    assign prdata_out = s_q.prdata;
    assign pready_out = s_q.pready;
    assign pslverr_out = s_q.pslverr;
    assign indicator_outputs_out = s_q.led;
    assign line_tx_lpi_out = s_q.line_lpi;
    assign packet_generator_lpi_out = s_q.gen_lpi;
    assign mac_rx_out = s_q.rx;
    assign receive_clock_output_out = s_q.rx_clk;
    assign rx_clk_delay_out = s_q.rx_dly;
    assign te_mode_out = s_q.te_en;
    assign gig_force_out = s_q.gig_force;
endmodule

// pgc_lane_rev: mirrors the bit order of one receive lane
module pgc_lane_rev #(
    parameter int WIDTH = 8
) (
    // lane in and out
    input wire logic [WIDTH-1:0] lane_in,
    output logic [WIDTH-1:0] lane_out
);
    import pgc_pkg::*;

    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            lane_out[i] = lane_in[WIDTH - 1 - i];
        end
    end
endmodule

// pgc_led_pol: one indicator pin, active low unless its polarity bit is set
module pgc_led_pol (
    // activity and polarity
    input wire logic act_in,
    input wire logic invert_in,
    // pin level
    output logic pin_out
);
    import pgc_pkg::*;

    assign pin_out = act_in ^ ~invert_in;
endmodule

// ==== verification/pgc_bank_props.sv ====
// pgc_bank_props.sv: port checker for the page 2 register bank
// assumes: bound to pgc_bank, one clock domain
`timescale 1ns/1ps
module pgc_bank_props (
    // clock, reset and bus
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // datapath
    input wire logic [1:0] speed_sel_in,
    input wire logic gig_force_out,
    input wire logic line_rx_lpi_in,
    input wire pgc_pkg::pgc_rx_t mac_rx_out,
    input wire logic rx_clk_raw_in,
    input wire logic receive_clock_output_out
);
    import pgc_pkg::*;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_access;
        psel_in && penable_in;
    endsequence
    a_bus_answer: assert property (s_setup ##1 s_access |=> pready_out)
        else $error("no answer");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("long ready");
    a_ready_cause: assert property (pready_out |-> $past(psel_in && penable_in))
        else $error("stray ready");
    a_err_align: assert property (s_access ##0 !pready_out ##0 paddr_in[1:0] != 2'h0
        |=> pslverr_out)
        else $error("misaligned accepted");
    a_rd_upper: assert property (pready_out |-> prdata_out[31:16] == 16'h0)
        else $error("upper read bits");
    a_gig_force: assert property (gig_force_out |-> $past(speed_sel_in) == 2'b10)
        else $error("force without speed");
    a_rx_lpi: assert property (mac_rx_out.lpi |-> $past(line_rx_lpi_in))
        else $error("rx lpi invented");
    a_clk_pass: assert property (receive_clock_output_out |-> $past(rx_clk_raw_in))
        else $error("rx clock invented");
endmodule

bind pgc_bank pgc_bank_props u_props (.core_clk_in, .rst_n_in, .psel_in, .penable_in,
    .paddr_in, .prdata_out, .pready_out, .pslverr_out, .speed_sel_in, .gig_force_out,
    .line_rx_lpi_in, .mac_rx_out, .rx_clk_raw_in, .receive_clock_output_out);

// ==== verification/tb_top.sv ====
// tb_top.sv: self-checking random bench for pgc_bank
// assumes: pgc_pkg and pgc_cfg.svh compiled first, default parameters
`timescale 1ns/1ps
`include "pgc_cfg.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    import pgc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [31:0] paddr = '0, pwdata = '0, prdata;
    logic [22:0] r = '0;
    logic pready, pslverr, ltx, plpi, rclk, te, gf, err;
    logic [3:0] ind;
    logic [2:0] dly;
    logic [15:0] rd, e, m;
    pgc_rx_t mrx;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    always #2.5 clk = ~clk;
    pgc_bank u_dut (.core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .link_up_in(r[0]), .eee_gig_in(r[1]),
        .eee_fast_in(r[2]), .speed_in(pgc_speed_t'(r[4:3])), .speed_sel_in(r[6:5]),
        .gmii_mode_in(r[7]), .led_act_in(r[11:8]), .indicator_outputs_out(ind),
        .mac_tx_lpi_in(r[12]), .line_tx_lpi_out(ltx), .packet_generator_lpi_out(plpi),
        .line_rx_lpi_in(r[13]), .rx_data_in(r[21:14]), .rx_clk_raw_in(r[22]),
        .mac_rx_out(mrx), .receive_clock_output_out(rclk), .rx_clk_delay_out(dly),
        .te_mode_out(te), .gig_force_out(gf));
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one apb transfer, data taken at the rising edge where pready is high
    task automatic apb(input logic w, input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {25'h0, a};
        pwdata <= {16'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata[15:0];
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    function automatic logic [7:0] rev(input logic [7:0] d, input logic g);
        rev = g ? {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]}
                : {d[7:4], d[0], d[1], d[2], d[3]};
    endfunction
    task automatic chk_dp(input logic [15:0] x, input logic [15:0] y);
        logic g;
        logic it;
        logic ir;
        g = r[4:3] == 2'b10;
        it = g ? x[1] : r[4:3] == 2'b01 && x[3];
        ir = g ? x[0] : r[4:3] == 2'b01 && x[2];
        `CHK(ind, r[11:8] ^ ~x[13:10])
        `CHK(te, x[15])
        `CHK(gf, x[5] && r[6:5] == 2'b10)
        `CHK(plpi, x[4])
        `CHK(ltx, x[4] || (r[12] && !it))
        `CHK(mrx.lpi, r[13] && !ir)
        `CHK(mrx.data, y[7] ? rev(r[21:14], r[7]) : r[21:14])
        `CHK(rclk, r[22] && !y[11])
        `CHK(dly, y[6:4])
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    initial
    begin
        void'($urandom(84569));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 7'h44, 16'h0);
        `CHK(err, 1'b1)
        apb(1'b1, 7'h7c, `PGC_PAGE_EXT2);
        apb(1'b0, 7'h50, 16'h0);
        `CHK(rd, `PGC_MAC_RST)
        apb(1'b1, 7'h48, 16'hffff);
        apb(1'b0, 7'h48, 16'h0);
        `CHK(rd, 16'h0001)
        apb(1'b0, 7'h4c, 16'h0);
        `CHK(err, 1'b1)
        apb(1'b0, 7'h45, 16'h0);
        `CHK(err, 1'b1)
        $display("test map done");
        for (int i = 0; i < 16; i++)
        begin
            e = 16'($urandom);
            m = 16'($urandom);
            m[6:4] = i[2:0];
            apb(1'b1, 7'h44, e);
            apb(1'b1, 7'h50, m);
            r <= 23'($urandom);
            repeat (2) @(negedge clk);
            chk_dp(e, m);
            apb(1'b0, 7'h44, 16'h0);
            `CHK(rd, (e & `PGC_EEE_RW_MASK) | {7'h0, r[0], r[1], r[2], 6'h0})
            `CHK(err, 1'b0)
            apb(1'b0, 7'h50, 16'h0);
            `CHK(rd, m & `PGC_MAC_RW_MASK)
        end
        $display("test random done");
        apb(1'b1, 7'h44, 16'h0010);
        repeat (2) @(negedge clk);
        `CHK(plpi, 1'b1)
        `CHK(ltx, 1'b1)
        apb(1'b1, 7'h44, 16'h0000);
        repeat (2) @(negedge clk);
        `CHK(plpi, 1'b0)
        $display("test lpi done");
        apb(1'b1, 7'h00, 16'h8000);
        apb(1'b0, 7'h44, 16'h0);
        `CHK(err, 1'b1)
        apb(1'b1, 7'h7c, `PGC_PAGE_EXT2);
        apb(1'b0, 7'h50, 16'h0);
        `CHK(rd, m & `PGC_MAC_RW_MASK)
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        chk_dp(16'h0, `PGC_MAC_RST);
        $display("test reset done");
        stop_test();
    end
endmodule
